// File: rtl/wdw_top.sv
// window watchdog supervisor: reset delay, window sequencer, fault output and status port
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module wdw_top #(
    parameter int CNT_W = 36,
    parameter logic [35:0] RST_DLY_SHORT = wdw_pkg::RST_DLY_SHORT_CYC[35:0],
    parameter logic [35:0] RST_DLY_LONG = wdw_pkg::RST_DLY_LONG_CYC[35:0],
    parameter logic [35:0] WDU_SHORT = wdw_pkg::WDU_SHORT_CYC[35:0],
    parameter logic [35:0] WDU_LONG = wdw_pkg::WDU_LONG_CYC[35:0]
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic rail_ok_in,
    input wire logic watchdog_kick_in,
    input wire logic window_select_a_in,
    input wire logic window_select_b_in,
    input wire logic watchdog_timing_pin_in,
    input wire logic reset_delay_pin_in,
    output logic reset_n_out,
    output logic reset_n_oe_out,
    output logic watchdog_fault_n_out,
    output logic watchdog_fault_n_oe_out,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out
);

    //==============================================================
    // strap decode
    logic [1:0] sel;
    logic wd_disabled;
    logic [CNT_W-1:0] upper_len;
    logic [CNT_W-1:0] lower_len;
    logic [CNT_W-1:0] rst_len;

    assign sel = {window_select_b_in, window_select_a_in};
    assign wd_disabled = (sel == wdw_pkg::SEL_DISABLE);
    assign upper_len = watchdog_timing_pin_in ? WDU_LONG : WDU_SHORT;
    assign rst_len = reset_delay_pin_in ? RST_DLY_LONG : RST_DLY_SHORT;

    // lower bound as a power-of-two fraction keeps the divider free
    always_comb begin
        case (sel)
            wdw_pkg::SEL_RATIO_HALF: lower_len = upper_len >> 1;
            wdw_pkg::SEL_RATIO_QUARTER: lower_len = upper_len >> 2;
            wdw_pkg::SEL_RATIO_EIGHTH: lower_len = upper_len >> 3;
            default: lower_len = '0;
        endcase
    end

    //==============================================================
    // supply reset sequencing
    logic por_r;
    logic rst_busy;
    logic reset_low;

    // first cycle after reset forces a full delay, as after power-up
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            por_r <= 1'b1;
        end else begin
            por_r <= 1'b0;
        end
    end

    wdw_delay_timer #(
        .CNT_W(CNT_W)
    ) u_rst_timer (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .load_in(!rail_ok_in || por_r),
        .clear_in(1'b0),
        .len_in(rst_len),
        .busy_out(rst_busy),
        .done_out()
    );

    // reset held while the rail is bad and for the whole count after
    assign reset_low = !rail_ok_in || por_r || rst_busy;

    //==============================================================
    // window sequencer
    wdw_pkg::wdw_state_t state_r;
    logic [CNT_W-1:0] win_cnt_r;
    logic kick_fall;
    logic fault_busy;
    logic fault_start;
    logic early_evt;
    logic late_evt;
    logic kick_enable;

    // kicks only count while outputs are released and the dog is on
    assign kick_enable = !reset_low && !fault_busy && !wd_disabled;

    wdw_kick_edge u_kick_edge (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .kick_in(watchdog_kick_in),
        .enable_in(kick_enable),
        .fall_out(kick_fall)
    );

    assign early_evt = (state_r == wdw_pkg::WDW_CLOSED) && kick_fall;
    assign late_evt = (state_r == wdw_pkg::WDW_OPEN) && !kick_fall
        && (win_cnt_r >= upper_len - 1'b1);
    assign fault_start = (early_evt || late_evt) && !reset_low;

    // the state machine falls back to off whenever reset or disable stands
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_r <= wdw_pkg::WDW_OFF;
        end else if (reset_low || wd_disabled) begin
            state_r <= wdw_pkg::WDW_OFF;
        end else begin
            case (state_r)
                wdw_pkg::WDW_OFF: begin
                    state_r <= wdw_pkg::WDW_CLOSED;
                end
                wdw_pkg::WDW_CLOSED: begin
                    if (fault_start) begin
                        state_r <= wdw_pkg::WDW_FAULT;
                    end else if (win_cnt_r >= lower_len - 1'b1) begin
                        state_r <= wdw_pkg::WDW_OPEN;
                    end
                end
                wdw_pkg::WDW_OPEN: begin
                    if (fault_start) begin
                        state_r <= wdw_pkg::WDW_FAULT;
                    end else if (kick_fall) begin
                        state_r <= wdw_pkg::WDW_CLOSED;
                    end
                end
                wdw_pkg::WDW_FAULT: begin
                    // fault_busy rises in the cycle of entry and win_cnt_r copies it a cycle late, so wait on both
                    if (!fault_busy && !fault_start && win_cnt_r != '0) begin
                        state_r <= wdw_pkg::WDW_CLOSED;
                    end
                end
                default: begin
                    state_r <= wdw_pkg::WDW_OFF;
                end
            endcase
        end
    end

    // window counter restarts on every accepted kick and on every fault
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            win_cnt_r <= '0;
        end else if (state_r == wdw_pkg::WDW_OFF || fault_start || kick_fall) begin
            win_cnt_r <= '0;
        end else if (state_r == wdw_pkg::WDW_FAULT) begin
            win_cnt_r <= {{(CNT_W-1){1'b0}}, fault_busy}; // zero at exit, so closed starts at 0
        end else begin
            win_cnt_r <= win_cnt_r + 1'b1;
        end
    end

    //==============================================================
    // fault pulse: one reset delay long, aborted by a supply reset
    wdw_delay_timer #(
        .CNT_W(CNT_W)
    ) u_fault_timer (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .load_in(fault_start),
        .clear_in(reset_low),
        .len_in(rst_len),
        .busy_out(fault_busy),
        .done_out()
    );

    // open-drain pins: value always low, enable is the pull-down
    assign reset_n_out = 1'b0;
    assign reset_n_oe_out = reset_low;
    assign watchdog_fault_n_out = 1'b0;
    assign watchdog_fault_n_oe_out = fault_busy && !reset_low;

    //==============================================================
    // status, mask and read port
    logic [2:0] status_r;
    logic [2:0] mask_r;
    logic [2:0] evt;
    logic [2:0] clr;
    logic reset_low_d_r;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reset_low_d_r <= 1'b0;
        end else begin
            reset_low_d_r <= reset_low;
        end
    end

    assign evt = {reset_low && !reset_low_d_r, late_evt && fault_start, early_evt && fault_start};
    assign clr = (reg_wr_in && reg_addr_in == wdw_pkg::REG_STATUS) ? reg_wdata_in[2:0] : 3'h0;

    // a set in the clearing cycle wins, so no event is lost
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            status_r <= wdw_pkg::STATUS_RST;
        end else begin
            status_r <= (status_r & ~clr) | evt;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            mask_r <= wdw_pkg::MASK_RST;
        end else if (reg_wr_in && reg_addr_in == wdw_pkg::REG_MASK) begin
            mask_r <= reg_wdata_in[2:0];
        end
    end

    // read data stand only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                wdw_pkg::REG_STATUS: reg_rdata_out <= {29'h0, status_r};
                wdw_pkg::REG_MASK: reg_rdata_out <= {29'h0, mask_r};
                wdw_pkg::REG_STATE: reg_rdata_out <= {26'h0, state_r, wd_disabled,
                    fault_busy, reset_low, rail_ok_in};
                default: reg_rdata_out <= 32'h0;
            endcase
        end else begin
            reg_rdata_out <= 32'h0;
        end
    end

    assign irq_out = |(status_r & mask_r);

    //==============================================================
    // checks
    logic [CNT_W-1:0] fault_len_r;
    logic [CNT_W-1:0] fault_cnt_r;

    // helper: expected and measured fault length
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            fault_len_r <= '0;
            fault_cnt_r <= '0;
        end else begin
            if (fault_start) begin
                fault_len_r <= rst_len;
            end
            if (fault_start) begin
                fault_cnt_r <= '0;
            end else if (fault_busy) begin
                fault_cnt_r <= fault_cnt_r + 1'b1;
            end
        end
    end

    a_fault_needs_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        watchdog_fault_n_oe_out |-> !reset_n_oe_out && $past(!reset_n_oe_out))
        else $error("fault driven while reset low");

    a_release_in_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (reset_low && rst_busy) |=> !watchdog_fault_n_oe_out)
        else $error("fault pin not released during reset");

    a_early_kick_fault: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_r == wdw_pkg::WDW_CLOSED && kick_fall && !reset_low && rail_ok_in)
        |=> watchdog_fault_n_oe_out || reset_low)
        else $error("early kick did not raise fault");

    a_fault_length: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        ($fell(fault_busy) && !reset_low) |-> (fault_cnt_r == fault_len_r))
        else $error("fault pulse length wrong");

    a_fault_starts: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(fault_busy) |-> $past(late_evt || early_evt))
        else $error("fault without window violation");

    a_disabled_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (wd_disabled && !fault_busy) |=> !fault_busy)
        else $error("fault raised while disabled");

    a_kick_in_fault: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        fault_busy |-> !kick_fall)
        else $error("kick accepted during fault");

    a_rail_bad_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (!rail_ok_in && rst_len > 36'h2) |=> reset_n_oe_out [*2])
        else $error("reset released too soon after rail fault");

    a_late_from_open: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(status_r[wdw_pkg::ST_LATE]) |-> $past(state_r) == wdw_pkg::WDW_OPEN)
        else $error("late flag not from open window");

    a_lower_ratio: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (sel == wdw_pkg::SEL_RATIO_QUARTER) |-> (lower_len * 4 <= upper_len)
        && (lower_len * 4 + 4 > upper_len))
        else $error("lower bound ratio wrong");

    a_unmapped_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in > wdw_pkg::REG_STATE) |=> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");

    // window boundaries: reset is excluded since it forces the sequencer off, and disable too except at the upper bound
    a_window_restart: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_r == wdw_pkg::WDW_FAULT && !fault_busy && win_cnt_r != '0 && !reset_low
        && !wd_disabled) |=> (state_r == wdw_pkg::WDW_CLOSED && win_cnt_r == '0))
        else $error("window did not restart after fault");

    a_open_at_lower: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_r == wdw_pkg::WDW_CLOSED && win_cnt_r == lower_len - 1'b1 && !kick_fall
        && !reset_low && !wd_disabled) |=> state_r == wdw_pkg::WDW_OPEN)
        else $error("window did not open at lower bound");

    a_late_timeout: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (state_r == wdw_pkg::WDW_OPEN && win_cnt_r == upper_len - 1'b1 && !kick_fall
        && !reset_low) |=> watchdog_fault_n_oe_out || reset_n_oe_out)
        else $error("missed upper bound did not raise fault");

    a_reset_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $rose(reset_low) |=> status_r[wdw_pkg::ST_RESET])
        else $error("reset entry not flagged");

    a_rdata_one_cycle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data held past its cycle");

    a_disabled_off: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        wd_disabled |=> state_r == wdw_pkg::WDW_OFF)
        else $error("sequencer running while disabled");

    c_good_kick: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        state_r == wdw_pkg::WDW_OPEN && kick_fall);
    c_early_fault: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        early_evt && fault_start);
    c_late_fault: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        late_evt && fault_start);
    c_fault_end: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $fell(fault_busy) && !reset_low);
    c_fault_abort: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        $fell(fault_busy) && reset_low);

endmodule // wdw_top

// File: common/wdw_pkg.sv
// constants, types and register map of the window watchdog supervisor
//==============================================================
// Operation
// - the host must give a falling kick edge between the lower and upper window bounds, or the fault asserts.
// - kicks are ignored while the reset output or the fault output is low.
// - with the watchdog disabled by the straps every kick is disregarded.
// - the two window straps and the timing pin choose the window ratio and timeout or disable the watchdog.
// - a watchdog timeout drives the active-low fault output low.
// - the fault output may only assert while the reset output is high.
// - each fault assertion lasts exactly the selected reset delay and is then released.
// - while the reset output is low the fault output is released, not driven.
// - the smallest and largest reset delay settings give 703 us and 3.22 s.
// - the smallest and largest timing settings give upper bounds of 62.74 ms and 77.45 s.
// - reset is held low while the rail is bad and released when the delay count completes after recovery.
// - the lower window bound is the upper bound scaled by the ratio the straps choose.
package wdw_pkg;

    //==============================================================
    // clock and timing
    localparam logic [63:0] CLK_KHZ = 64'd200000;
    localparam logic [63:0] RST_DLY_SHORT_US = 64'd703;
    localparam logic [63:0] RST_DLY_LONG_MS = 64'd3220;
    localparam logic [63:0] WDU_SHORT_US = 64'd62740;
    localparam logic [63:0] WDU_LONG_MS = 64'd77450;
    localparam logic [63:0] RST_DLY_SHORT_CYC = RST_DLY_SHORT_US * CLK_KHZ / 64'd1000;
    localparam logic [63:0] RST_DLY_LONG_CYC = RST_DLY_LONG_MS * CLK_KHZ;
    localparam logic [63:0] WDU_SHORT_CYC = WDU_SHORT_US * CLK_KHZ / 64'd1000;
    localparam logic [63:0] WDU_LONG_CYC = WDU_LONG_MS * CLK_KHZ;

    //==============================================================
    // strap encodings of {window_select_b, window_select_a}
    localparam logic [1:0] SEL_RATIO_HALF = 2'h0;
    localparam logic [1:0] SEL_RATIO_QUARTER = 2'h1;
    localparam logic [1:0] SEL_RATIO_EIGHTH = 2'h2;
    localparam logic [1:0] SEL_DISABLE = 2'h3;

    //==============================================================
    // register map, byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_STATE = 8'h08;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam int ST_EARLY = 0;
    localparam int ST_LATE = 1;
    localparam int ST_RESET = 2;

    //==============================================================
    // watchdog sequencer states
    typedef enum logic [1:0] {
        WDW_OFF,
        WDW_CLOSED,
        WDW_OPEN,
        WDW_FAULT
    } wdw_state_t;

endpackage

// File: rtl/wdw_delay_timer.sv
// loadable down-counter that stays busy for exactly the loaded number of cycles
`timescale 1ns/1ps
module wdw_delay_timer #(
    parameter int CNT_W = 36
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic load_in,
    input wire logic clear_in,
    input wire logic [CNT_W-1:0] len_in,
    output logic busy_out,
    output logic done_out
);
    logic [CNT_W-1:0] cnt_r;

    // holding load keeps the count at full length; clear wins over load
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
        end else if (clear_in) begin
            cnt_r <= '0;
        end else if (load_in) begin
            cnt_r <= len_in;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign busy_out = (cnt_r != '0);
    assign done_out = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}) && !load_in && !clear_in;
endmodule // wdw_delay_timer

// File: rtl/wdw_kick_edge.sv
// falling-edge detector for the kick input, qualified by an enable
`timescale 1ns/1ps
module wdw_kick_edge (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic kick_in,
    input wire logic enable_in,
    output logic fall_out
);
    logic prev_r;

    // the history always tracks the pin so enabling never fakes an edge
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= kick_in;
        end
    end

    assign fall_out = enable_in && prev_r && !kick_in;
endmodule // wdw_kick_edge

// File: tb/wdw_host_model.sv
// host processor model: kicks the watchdog a set count after each restart
`timescale 1ns/1ps
module wdw_host_model (
    input wire logic clk_sys_in,
    input wire logic reset_pin_in,
    input wire logic fault_pin_in,
    input wire logic arm_in,
    input wire logic glitch_in,
    input wire logic [15:0] delay_in,
    output logic kick_out
);
    logic [15:0] cnt_r;

    //==============================================================
    // kick sequencing
    initial begin
        kick_out = 1'b1;
        cnt_r = 16'h0000;
    end

    // counts only while both pins are released; glitch mode toggles the kick every cycle
    always @(posedge clk_sys_in) begin
        if (glitch_in) begin
            kick_out <= ~kick_out;
        end else if (!reset_pin_in || !fault_pin_in) begin
            kick_out <= 1'b1;
            cnt_r <= 16'h0000;
        end else if (arm_in && cnt_r == delay_in) begin
            kick_out <= 1'b0;
            cnt_r <= 16'h0000;
        end else begin
            kick_out <= 1'b1;
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule // wdw_host_model

// File: tb/testbench.sv
// self-checking bench for the window watchdog supervisor
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic rail_ok = 1'b0;
    logic sel_a = 1'b0;
    logic sel_b = 1'b0;
    logic tp = 1'b0;
    logic dp = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic arm = 1'b0;
    logic glitch = 1'b0;
    logic [15:0] delay = 16'h0000;
    logic [31:0] lfsr = 32'hf83a;
    logic [31:0] reg_rdata;
    logic kick, reset_n, reset_oe, fault_n, fault_oe, irq;
    int n_mismatch = 0;
    int n_compared = 0;
    int run_len = 0;
    int last_len = 0;

    //==============================================================
    // design and host; counts shortened so a run stays small
    wdw_top #(.RST_DLY_SHORT(36'h14), .RST_DLY_LONG(36'h28), .WDU_SHORT(36'h40),
        .WDU_LONG(36'h80)) dut_u (
        .clk_sys_in(clk_sys), .rst_n_in(rst_n), .rail_ok_in(rail_ok),
        .watchdog_kick_in(kick), .window_select_a_in(sel_a), .window_select_b_in(sel_b),
        .watchdog_timing_pin_in(tp), .reset_delay_pin_in(dp), .reset_n_out(reset_n),
        .reset_n_oe_out(reset_oe), .watchdog_fault_n_out(fault_n),
        .watchdog_fault_n_oe_out(fault_oe), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .irq_out(irq));
    // pins are pulled up, so a released pin reads high
    wdw_host_model host_u (.clk_sys_in(clk_sys), .reset_pin_in(reset_oe ? reset_n : 1'b1),
        .fault_pin_in(fault_oe ? fault_n : 1'b1), .arm_in(arm), .glitch_in(glitch),
        .delay_in(delay), .kick_out(kick));

    //==============================================================
    // clock, fault pulse length, watchdog
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // sampled at the edge, so it sees the settled pre-edge level
    always @(posedge clk_sys) begin
        if (fault_oe === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            last_len <= run_len;
            run_len <= 0;
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end

    //==============================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_range(input string nm, input int lo, input int hi, input int g);
        n_compared++;
        if (g < lo || g > hi) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_fault(input logic lvl, input int max, output int n);
        n = 0;
        while (fault_oe !== lvl && n < max) begin
            tick(1);
            n++;
        end
        if (fault_oe !== lvl) begin
            n_mismatch++;
            $display("CHECK FAILED fault_wait expected %b seen %b", lvl, fault_oe);
        end
    endtask

    // rail drops with new straps, then returns; n is the reset delay seen
    task automatic restart(input logic [1:0] s, input logic t, input logic d, output int n);
        @(posedge clk_sys);
        rail_ok <= 1'b0;
        arm <= 1'b0;
        {sel_b, sel_a} <= s;
        tp <= t;
        dp <= d;
        tick(4);
        chk_bit("reset_held", 1'b1, reset_oe);
        chk_bit("fault_hiz", 1'b0, fault_oe);
        chk_bit("reset_level", 1'b0, reset_n);
        @(posedge clk_sys);
        rail_ok <= 1'b1;
        glitch <= 1'b0;
        n = 0;
        tick(1);
        while (reset_oe !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    //==============================================================
    // main sequence: one pass per strap setting, then disable and abort cases
    initial begin
        int n, up, lo, rl, flt;
        logic [31:0] d;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        reg_rd_t(8'h0c, d);
        chk_word("unmapped", 32'h0, d);
        reg_wr_t(wdw_pkg::REG_MASK, 32'h2);
        reg_rd_t(wdw_pkg::REG_MASK, d);
        chk_word("mask", 32'h2, d);
        for (int i = 0; i < 3; i++) begin
            up = i[0] ? 128 : 64;
            lo = up >> (i + 1);
            rl = (i != 0) ? 40 : 20;
            restart(i[1:0], i[0], i != 0, n);
            chk_range("reset_delay", rl - 1, rl + 2, n);
            reg_wr_t(wdw_pkg::REG_STATUS, 32'h7);
            wait_fault(1'b1, up + 20, n);
            chk_range("timeout", up - 2, up + 3, n + 2);
            chk_bit("fault_level", 1'b0, fault_n);
            chk_bit("irq_set", 1'b1, irq);
            reg_rd_t(wdw_pkg::REG_STATUS, d);
            chk_word("status_late", 32'h2, d);
            reg_wr_t(wdw_pkg::REG_STATUS, 32'h7);
            chk_bit("irq_clear", 1'b0, irq);
            @(posedge clk_sys);
            arm <= 1'b1;
            delay <= 16'(lo - 4);
            wait_fault(1'b0, 100, n);
            tick(2);
            chk_range("fault_len", rl, rl, last_len);
            wait_fault(1'b1, up, n);
            chk_range("early_kick", 1, lo, n);
            chk_bit("irq_masked", 1'b0, irq);
            reg_rd_t(wdw_pkg::REG_STATUS, d);
            chk_word("status_early", 32'h1, d);
            reg_wr_t(wdw_pkg::REG_STATUS, 32'h7);
            lfsr = lfsr_next(lfsr);
            @(posedge clk_sys);
            glitch <= 1'b1;
            delay <= 16'(lo + 4) + lfsr[15:0] % 16'(up - lo - 8);
            tick(6);
            @(posedge clk_sys);
            glitch <= 1'b0;
            reg_rd_t(wdw_pkg::REG_STATUS, d);
            chk_word("kick_in_fault", 32'h0, d);
            wait_fault(1'b0, 100, n);
            tick(2);
            chk_range("fault_len2", rl, rl, last_len);
            flt = 0;
            repeat (3 * up) begin
                tick(1);
                if (fault_oe !== 1'b0) flt++;
            end
            chk_range("good_kicks", 0, 0, flt);
            $display("window pass %0d done", i);
        end
        restart(2'h3, 1'b0, 1'b0, n);
        chk_range("reset_delay_off", 19, 22, n);
        @(posedge clk_sys);
        glitch <= 1'b1;
        flt = 0;
        repeat (300) begin
            tick(1);
            if (fault_oe !== 1'b0) flt++;
        end
        chk_range("disabled", 0, 0, flt);
        reg_rd_t(wdw_pkg::REG_STATE, d);
        chk_word("state_off", 32'h9, d);
        $display("disable test done");
        restart(2'h0, 1'b0, 1'b0, n);
        wait_fault(1'b1, 100, n);
        tick(3);
        @(posedge clk_sys);
        rail_ok <= 1'b0;
        #1;
        chk_bit("abort_hiz", 1'b0, fault_oe);
        chk_bit("abort_reset", 1'b1, reset_oe);
        $display("abort test done");
        wrap_up();
    end
endmodule // testbench
